// [common/tssc_pkg.sv]
// constants shared by the thermometer serial control block
package tssc_pkg;
	// ==========================================================
	// command indices
	localparam logic [7:0] CMD_LOCAL_WHOLE = 8'h00;
	localparam logic [7:0] CMD_REMOTE_WHOLE = 8'h01;
	localparam logic [7:0] CMD_STATUS = 8'h02;
	localparam logic [7:0] CMD_CFG_RD = 8'h03;
	localparam logic [7:0] CMD_RATE_RD = 8'h04;
	localparam logic [7:0] CMD_CFG_WR = 8'h09;
	localparam logic [7:0] CMD_RATE_WR = 8'h0A;
	localparam logic [7:0] CMD_SINGLE_CONV = 8'h0F;
	localparam logic [7:0] CMD_REMOTE_FRAC = 8'h10;
	localparam logic [7:0] CMD_LOCAL_FRAC = 8'h11;
	localparam logic [7:0] CMD_ID = 8'hFE;
	localparam logic [7:0] CMD_REV = 8'hFF;
	// ==========================================================
	// field positions and reset values
	localparam int CFG_STANDBY_BIT = 6;
	localparam int CFG_EXT_RANGE_BIT = 5;
	localparam int CFG_SRC_BIT = 4;
	localparam int STAT_BUSY_BIT = 7;
	localparam int STAT_FAULT_BIT = 2;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] RATE_RESET = 8'h02;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [7:0] RATE_1HZ_CODE = 8'h04;
	localparam logic [2:0] RATE_MAX_CODE = 3'h7;
	// ==========================================================
	// temperature format
	localparam int RAW_W = 11;
	localparam logic [7:0] TEMP_SAT_HIGH = 8'h7F;
	localparam logic [7:0] TEMP_FAULT = 8'h80;
	localparam logic [11:0] TEMP_HALF = 12'h004;
	localparam logic signed [8:0] TEMP_MAX = 9'sh07F;
	localparam logic signed [8:0] TEMP_MIN_EXT = -9'sh040;
	// ==========================================================
	// timing
	localparam int CLK_HZ = 25_000_000;
	localparam int SLOWEST_PERIOD_S = 16;
	localparam int SLOWEST_PERIOD_CYC = SLOWEST_PERIOD_S * CLK_HZ;
endpackage

// [rtl/tssc_smbus_slave.sv]
// serial byte slave: start/stop detect, address match, byte shifting
`timescale 1ns/1ns
module tssc_smbus_slave import tssc_pkg::*; #(
	parameter logic [6:0] SLAVE_ADDR = 7'h18
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic [7:0] rd_data,
	output logic sda_out,
	output logic sda_oe,
	output logic rx_valid,
	output logic rx_is_cmd,
	output logic [7:0] rx_byte
);
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_ADDR = 3'b001, S_ADDR_ACK = 3'b010,
		S_RX = 3'b011, S_RX_ACK = 3'b100, S_TX = 3'b101,
		S_TX_ACK = 3'b110
	} tssc_slv_e;

	logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
	tssc_slv_e state_reg;
	logic [3:0] cnt_reg;
	logic [7:0] sh_reg, tx_reg;
	logic rw_reg;
	logic [1:0] idx_reg;
	logic start_c, stop_c, rise_c, fall_c;

	// ==========================================================
	// line synchronisers; only stage two and its delay are decoded
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			{scl_s1, scl_s2, scl_d} <= 3'h7;
			{sda_s1, sda_s2, sda_d} <= 3'h7;
		end else begin
			{scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
		end
	end
	assign start_c = scl_s2 & scl_d & sda_d & ~sda_s2;
	assign stop_c = scl_s2 & scl_d & ~sda_d & sda_s2;
	assign rise_c = scl_s2 & ~scl_d;
	assign fall_c = ~scl_s2 & scl_d;

	// ==========================================================
	// protocol engine; the line is only ever pulled low (open drain)
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= S_IDLE;
			cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			tx_reg <= 8'h00;
			rw_reg <= 1'b0;
			idx_reg <= 2'h0;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			rx_valid <= 1'b0;
			rx_is_cmd <= 1'b0;
			rx_byte <= 8'h00;
		end else begin
			rx_valid <= 1'b0;
			if (start_c) begin // repeated start handled alike
				state_reg <= S_ADDR;
				cnt_reg <= 4'h0;
				idx_reg <= 2'h0;
				sda_oe <= 1'b0;
			end else if (stop_c) begin
				state_reg <= S_IDLE;
				sda_oe <= 1'b0;
			end else if (rise_c) begin
				unique case (state_reg)
					S_ADDR, S_RX: begin
						sh_reg <= {sh_reg[6:0], sda_s2};
						cnt_reg <= cnt_reg + 4'h1;
					end
					S_TX_ACK: begin
						// master nack ends the read
						state_reg <= sda_s2 ? S_IDLE : S_TX;
						cnt_reg <= 4'h0;
					end
					default: ;
				endcase
			end else if (fall_c) begin
				unique case (state_reg)
					S_ADDR: if (cnt_reg == 4'h8) begin
						// one address for every function
						if (sh_reg[7:1] == SLAVE_ADDR) begin
							state_reg <= S_ADDR_ACK;
							rw_reg <= sh_reg[0];
							sda_oe <= 1'b1;
						end else begin
							state_reg <= S_IDLE;
						end
					end
					S_ADDR_ACK: if (rw_reg) begin
						// receive byte uses stored pointer
						state_reg <= S_TX;
						cnt_reg <= 4'h1;
						tx_reg <= rd_data;
						sda_oe <= ~rd_data[7];
					end else begin
						state_reg <= S_RX;
						cnt_reg <= 4'h0;
						sda_oe <= 1'b0;
					end
					S_RX: if (cnt_reg == 4'h8) begin
						// only command and one data byte taken
						if (idx_reg != 2'h2) begin
							state_reg <= S_RX_ACK;
							sda_oe <= 1'b1;
							rx_valid <= 1'b1;
							rx_is_cmd <= (idx_reg == 2'h0);
							rx_byte <= sh_reg;
							idx_reg <= idx_reg + 2'h1;
						end else begin
							state_reg <= S_IDLE;
						end
					end
					S_RX_ACK: begin
						state_reg <= S_RX;
						cnt_reg <= 4'h0;
						sda_oe <= 1'b0;
					end
					S_TX: if (cnt_reg == 4'h8) begin
						state_reg <= S_TX_ACK;
						sda_oe <= 1'b0;
					end else if (cnt_reg == 4'h0) begin
						tx_reg <= rd_data;
						sda_oe <= ~rd_data[7];
						cnt_reg <= 4'h1;
					end else begin
						// msb first
						sda_oe <= ~tx_reg[3'h7 - cnt_reg[2:0]];
						cnt_reg <= cnt_reg + 4'h1;
					end
					default: ;
				endcase
			end
		end
	end
endmodule

// [rtl/tssc_top.sv]
// thermometer control: serial registers, standby, conversion sequencing
`timescale 1ns/1ns
module tssc_top import tssc_pkg::*; #(
	parameter logic [6:0] SLAVE_ADDR = 7'h18,
	parameter logic [7:0] DEVICE_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] DEVICE_REV = 8'h01, // arbitrary value
	parameter int PERIOD_CYC = SLOWEST_PERIOD_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic hw_standby_n,
	input wire logic conv_done,
	input wire logic [RAW_W-1:0] conv_local_raw,
	input wire logic [RAW_W-1:0] conv_remote_raw,
	input wire logic conv_diode_fault,
	output logic conv_start,
	output logic conv_abort,
	output logic adc_enable,
	output logic series_resistance_cancel
);
	typedef enum logic [0:0] {
		C_IDLE = 1'b0,
		C_BUSY = 1'b1
	} tssc_conv_e;

	// ==========================================================
	// declarations
	logic hw_s1, hw_s2;
	logic [7:0] ptr_reg, cfg_reg, rate_reg;
	logic [7:0] local_temp_whole, remote_temp_whole;
	logic [7:0] local_temp_fraction, remote_temp_fraction;
	logic fault_reg;
	tssc_conv_e conv_reg;
	logic [31:0] timer_reg;
	logic single_req, sw_hw_standby_n_rise, standby_c, ext_rate_c;
	logic auto_due_c, start_c, abort_c;
	logic [7:0] rd_data_c;
	logic rx_valid, rx_is_cmd;
	logic [7:0] rx_byte;

	// ==========================================================
	// whole-degree format with rounding, saturation and fault code
	function automatic logic [7:0] tssc_whole(
		input logic [RAW_W-1:0] raw,
		input logic fault,
		input logic ext_range
	);
		logic [11:0] r;
		logic signed [8:0] w;
		r = {raw[RAW_W-1], raw} + TEMP_HALF; // round to nearest
		w = $signed(r[11:3]);
		if (fault) begin
			tssc_whole = TEMP_FAULT;
		end else if (w > TEMP_MAX) begin
			tssc_whole = TEMP_SAT_HIGH;
		end else if (w < 0 && !ext_range) begin
			tssc_whole = TEMP_FAULT;
		end else if (w < TEMP_MIN_EXT) begin
			tssc_whole = TEMP_FAULT;
		end else begin
			tssc_whole = w[7:0]; // two's complement, 1 degree lsb
		end
	endfunction

	// eighths in the top three bits, low five read as zero
	function automatic logic [7:0] tssc_frac(input logic [RAW_W-1:0] raw);
		tssc_frac = {raw[2:0], 5'h00};
	endfunction

	// ==========================================================
	// serial slave
	tssc_smbus_slave #(
		.SLAVE_ADDR(SLAVE_ADDR)
	) u_slave (
		.sys_clk(sys_clk),
		.rst(rst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.rd_data(rd_data_c),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.rx_valid(rx_valid),
		.rx_is_cmd(rx_is_cmd),
		.rx_byte(rx_byte)
	);

	// ==========================================================
	// standby pin synchroniser
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hw_s1 <= 1'b1;
			hw_s2 <= 1'b1;
		end else begin
			hw_s1 <= hw_standby_n;
			hw_s2 <= hw_s1;
		end
	end

	// standby from either source
	assign standby_c = ~hw_s2 | cfg_reg[CFG_STANDBY_BIT];
	// fractions only mean something at 1 Hz or slower
	assign ext_rate_c = (rate_reg <= RATE_1HZ_CODE);

	// ==========================================================
	// command pointer; reset to local reading
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ptr_reg <= PTR_RESET;
		end else if (rx_valid && rx_is_cmd) begin
			ptr_reg <= rx_byte; // kept for later receive byte
		end
	end

	// ==========================================================
	// configuration and rate; writes work in any standby
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg_reg <= CFG_RESET;
			rate_reg <= RATE_RESET;
		end else if (rx_valid && !rx_is_cmd) begin
			// data lands in register chosen by command
			unique case (ptr_reg)
				CMD_CFG_WR: cfg_reg <= rx_byte;
				CMD_RATE_WR: rate_reg <= rx_byte;
				default: ; // read-only or unknown index
			endcase
		end
	end

	// a write that newly sets the halt bit is a standby request
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sw_hw_standby_n_rise <= 1'b0;
		end else begin
			sw_hw_standby_n_rise <= rx_valid && !rx_is_cmd && ptr_reg == CMD_CFG_WR &&
				rx_byte[CFG_STANDBY_BIT] && !cfg_reg[CFG_STANDBY_BIT];
		end
	end

	// ==========================================================
	// single-conversion command, from send byte or write byte
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			single_req <= 1'b0;
		end else begin
			single_req <= rx_valid && rx_is_cmd && rx_byte == CMD_SINGLE_CONV;
		end
	end

	// ==========================================================
	// rate timer; counts down one period, restarted by single conversion
	assign auto_due_c = (timer_reg == 32'h0) && !standby_c;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			timer_reg <= 32'h0;
		end else if (start_c) begin
			// full delay after any start, manual ones included
			timer_reg <= 32'(PERIOD_CYC) >>
				(rate_reg > 8'(RATE_MAX_CODE) ? RATE_MAX_CODE : rate_reg[2:0]);
		end else if (timer_reg != 32'h0) begin
			timer_reg <= timer_reg - 32'h1;
		end
	end

	// ==========================================================
	// conversion sequencing
	// pin standby blocks all starts, software standby only automatic ones
	assign start_c = (conv_reg == C_IDLE) && hw_s2 &&
		(auto_due_c || single_req);
	// abort on pin low or on a new halt request
	assign abort_c = (conv_reg == C_BUSY) && (!hw_s2 || sw_hw_standby_n_rise);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			conv_reg <= C_IDLE;
		end else begin
			unique case (conv_reg)
				C_IDLE: if (start_c) begin
					conv_reg <= C_BUSY; // commands while busy are ignored
				end
				C_BUSY: if (abort_c || conv_done) begin
					// from standby, back to idle with no auto restart
					conv_reg <= C_IDLE;
				end
			endcase
		end
	end

	// converter strobes and enable are registered outputs
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			conv_start <= 1'b0;
			conv_abort <= 1'b0;
			adc_enable <= 1'b0;
		end else begin
			conv_start <= start_c;
			conv_abort <= abort_c;
			// converter off in pin standby; in software standby on only for a running conversion
			adc_enable <= (start_c || (conv_reg == C_BUSY && !abort_c &&
				!conv_done));
		end
	end

	// cancellation only honoured at slow rates, ignored when faster
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			series_resistance_cancel <= 1'b0;
		end else begin
			series_resistance_cancel <= cfg_reg[CFG_SRC_BIT] && ext_rate_c;
		end
	end

	// ==========================================================
	// results; an aborted conversion never lands here
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			local_temp_whole <= 8'h00;
			remote_temp_whole <= 8'h00;
			local_temp_fraction <= 8'h00;
			remote_temp_fraction <= 8'h00;
			fault_reg <= 1'b0;
		end else if (conv_reg == C_BUSY && conv_done && !abort_c) begin
			// main and fraction move together; reads straddling this
			// may pair old whole with new fraction
			local_temp_whole <= tssc_whole(conv_local_raw, 1'b0,
				cfg_reg[CFG_EXT_RANGE_BIT]);
			remote_temp_whole <= tssc_whole(conv_remote_raw,
				conv_diode_fault, cfg_reg[CFG_EXT_RANGE_BIT]);
			// at fast rates only whole degrees are valid
			local_temp_fraction <= ext_rate_c ?
				tssc_frac(conv_local_raw) : 8'h00;
			remote_temp_fraction <= (ext_rate_c && !conv_diode_fault) ?
				tssc_frac(conv_remote_raw) : 8'h00;
			fault_reg <= conv_diode_fault;
		end
	end

	// ==========================================================
	// read multiplexer feeding the slave's transmit byte
	always_comb begin
		unique case (ptr_reg)
			CMD_LOCAL_WHOLE: rd_data_c = local_temp_whole;
			CMD_REMOTE_WHOLE: rd_data_c = remote_temp_whole;
			CMD_STATUS: begin
				rd_data_c = 8'h00;
				rd_data_c[STAT_BUSY_BIT] = (conv_reg == C_BUSY);
				rd_data_c[STAT_FAULT_BIT] = fault_reg;
			end
			CMD_CFG_RD: rd_data_c = cfg_reg;
			CMD_RATE_RD: rd_data_c = rate_reg;
			CMD_REMOTE_FRAC: rd_data_c = remote_temp_fraction;
			CMD_LOCAL_FRAC: rd_data_c = local_temp_fraction;
			CMD_ID: rd_data_c = DEVICE_ID;
			CMD_REV: rd_data_c = DEVICE_REV;
			default: rd_data_c = 8'h00;
		endcase
	end
endmodule

// [bench/tssc_top_props.sv]
// assertions on the thermometer control top-level pins
`timescale 1ns/1ns
module tssc_top_props (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic hw_standby_n,
	input wire logic conv_done,
	input wire logic conv_start,
	input wire logic conv_abort,
	input wire logic adc_enable
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// ====
	// pin low long enough to clear the synchroniser
	sequence pin_low_s;
		!hw_standby_n [*6];
	endsequence
	// a whole serial clock high phase as the block sees it
	sequence scl_high_s;
		scl_in [*4];
	endsequence
	// ====
	// conversion control
	AST_PIN_NO_START:
		assert property (pin_low_s |-> !conv_start)
		else $error("conversion started under pin standby");
	AST_PIN_ADC_OFF:
		assert property (pin_low_s ##1 !hw_standby_n [*2] |-> !adc_enable)
		else $error("converter on under pin standby");
	AST_END_CAUSE:
		assert property ($fell(adc_enable) |->
			$past(conv_done) || conv_abort || $past(conv_abort))
		else $error("conversion ended without done or abort");
	AST_START_ENABLES:
		assert property (conv_start |-> adc_enable)
		else $error("start without converter enable");
	AST_START_PULSE:
		assert property (conv_start |=> !conv_start)
		else $error("start longer than one cycle");
	AST_ABORT_PULSE:
		assert property (conv_abort |=> !conv_abort)
		else $error("abort longer than one cycle");
	AST_ABORT_BUSY:
		assert property (conv_abort |-> $past(adc_enable))
		else $error("abort while idle");
	// ====
	// serial data line
	AST_SDA_QUIET:
		assert property (scl_high_s |-> $stable(sda_oe))
		else $error("data moved while serial clock high");
	AST_OPEN_DRAIN:
		assert property (sda_out == 1'h0)
		else $error("data line driven high");
endmodule
bind tssc_top tssc_top_props u_props (.sys_clk(sys_clk), .rst(rst),
	.scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.hw_standby_n(hw_standby_n), .conv_done(conv_done),
	.conv_start(conv_start), .conv_abort(conv_abort),
	.adc_enable(adc_enable));

// [bench/tssc_host_model.sv]
// host serial master model on the two-wire link
`timescale 1ns/1ns
module tssc_host_model (
	output logic scl,
	output logic sda_low,
	input wire logic sda_wire
);
	// ====
	// link idles high; the clock runs only inside frames
	initial begin
		scl = 1'h1;
		sda_low = 1'h0;
	end
	// one bit: data set mid-low, sampled late in the high half
	task automatic bit_io(input logic b, output logic r);
		sda_low = !b;
		#80 scl = 1'h1;
		#120 r = sda_wire;
		#40 scl = 1'h0;
		#80;
	endtask
	// start or repeated start; long low gives the slave time to let go
	task automatic start();
		sda_low = 1'h0;
		#160 scl = 1'h1;
		#80 sda_low = 1'h1;
		#80 scl = 1'h0;
		#80;
	endtask
	// eight bits msb first, then the acknowledge slot
	task automatic xfer(input logic [7:0] tx, input logic ack_in,
		output logic [7:0] rx, output logic ack_out);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
		bit_io(ack_in, ack_out);
	endtask
	// stop: data rises while the clock is high
	task automatic stop();
		sda_low = 1'h1;
		#160 scl = 1'h1;
		#80 sda_low = 1'h0;
		#160;
	endtask
endmodule

// [bench/tb_top.sv]
// self-checking bench for the thermometer control block
`timescale 1ns/1ns
module tb_top import tssc_pkg::*; ;
	localparam logic [6:0] ADDR = 7'h18;
	logic sys_clk = 1'h0, rst = 1'h1, hw_standby_n = 1'h1;
	logic conv_done = 1'h0, conv_diode_fault = 1'h0;
	logic [RAW_W-1:0] conv_local_raw = '0, conv_remote_raw = '0;
	wire logic scl, host_low, sda_wire;
	logic sda_out, sda_oe, conv_start, conv_abort, adc_enable, src_out;
	int n_errors = 0, compares = 0, cnt = 0, conv_len = 30;
	int n_starts = 0, n_aborts = 0, ptr = 0, k0;
	int seed = 32'hD70C0217;
	logic pend = 1'h0;
	logic [7:0] m [0:255];
	// ====
	always #20 sys_clk = ~sys_clk;
	// open drain line with pull-up
	assign sda_wire = !(host_low || sda_oe);
	tssc_top #(.PERIOD_CYC(2048)) dut (.sys_clk(sys_clk), .rst(rst),
		.scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
		.sda_oe(sda_oe), .hw_standby_n(hw_standby_n),
		.conv_done(conv_done), .conv_local_raw(conv_local_raw),
		.conv_remote_raw(conv_remote_raw),
		.conv_diode_fault(conv_diode_fault), .conv_start(conv_start),
		.conv_abort(conv_abort), .adc_enable(adc_enable),
		.series_resistance_cancel(src_out));
	tssc_host_model host (.scl(scl), .sda_low(host_low),
		.sda_wire(sda_wire));
	// ====
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// reference reading: round by half a degree, then clamp
	function automatic logic [7:0] whole(input logic [RAW_W-1:0] r,
		input logic f);
		int v;
		v = ($signed(r) + 4) >>> 3;
		if (f || (v < 0 && !m[3][CFG_EXT_RANGE_BIT]) || v < -64)
			return TEMP_FAULT;
		return (v > 127) ? TEMP_SAT_HIGH : v[7:0];
	endfunction
	// fractions only hold at the slow rates
	task automatic commit();
		logic fast;
		fast = m[4] > RATE_1HZ_CODE;
		m[2] = 8'h00;
		m[2][STAT_FAULT_BIT] = conv_diode_fault;
		m[0] = whole(conv_local_raw, 1'h0);
		m[1] = whole(conv_remote_raw, conv_diode_fault);
		m[17] = fast ? 8'h00 : {conv_local_raw[2:0], 5'h00};
		m[16] = (fast || conv_diode_fault) ? 8'h00 :
			{conv_remote_raw[2:0], 5'h00};
	endtask
	// converter stand-in; an abort throws the pending result away
	always @(negedge sys_clk) begin
		conv_done <= 1'h0;
		if (pend && !conv_abort)
			commit();
		pend = 1'h0;
		if (conv_abort) begin
			n_aborts++;
			cnt = 0;
		end else if (conv_start) begin
			n_starts++;
			cnt = conv_len;
		end else if (cnt == 1) begin
			cnt = 0;
			pend = 1'h1;
			conv_done <= 1'h1;
		end else if (cnt > 1)
			cnt--;
	end
	// kinds: 0 write byte, 1 send byte, 2 read byte, 3 receive byte
	task automatic txn(input int k, input logic [7:0] c,
		input logic [7:0] d);
		logic [7:0] rx;
		logic a;
		host.start();
		if (k != 3) begin
			host.xfer({ADDR, 1'h0}, 1'h1, rx, a);
			chk({7'h00, a}, 8'h00);
			host.xfer(c, 1'h1, rx, a);
			chk({7'h00, a}, 8'h00);
			ptr = c;
		end
		if (k == 0) begin
			host.xfer(d, 1'h1, rx, a);
			chk({7'h00, a}, 8'h00);
			if (c == CMD_CFG_WR)
				m[3] = d;
			if (c == CMD_RATE_WR)
				m[4] = d;
		end
		if (k >= 2) begin
			if (k == 2)
				host.start();
			host.xfer({ADDR, 1'h1}, 1'h1, rx, a);
			chk({7'h00, a}, 8'h00);
			host.xfer(8'hFF, 1'h1, rx, a);
			chk(rx, m[ptr]);
		end
		host.stop();
	endtask
	// bounded waits on the converter stand-in
	task automatic wait_idle();
		int t;
		t = 0;
		while ((n_starts == k0 || cnt != 0 || pend) && t < 4000) begin
			@(negedge sys_clk);
			t++;
		end
		chk({7'h00, t == 4000}, 8'h00);
		chk(8'(n_starts - k0), 8'h01);
	endtask
	task automatic wait_busy();
		int t;
		t = 0;
		while (cnt == 0 && t < 2000) begin
			@(negedge sys_clk);
			t++;
		end
		chk({7'h00, t == 2000}, 8'h00);
	endtask
	// ====
	initial begin
		logic [7:0] rx;
		logic a;
		logic src;
		foreach (m[i])
			m[i] = 8'h00;
		m[4] = RATE_RESET;
		repeat (16) @(negedge sys_clk);
		rst = 1'h0;
		repeat (8) @(negedge sys_clk);
		txn(3, 8'h00, 8'h00);
		txn(0, CMD_CFG_WR, 8'h40);
		txn(2, CMD_CFG_RD, 8'h00);
		// every rate code, random readings, with and without fault
		for (int i = 0; i < 8; i++) begin
			@(negedge sys_clk);
			src = 1'($random(seed));
			conv_diode_fault = (i % 3) == 2;
			conv_remote_raw = RAW_W'($random(seed));
			conv_local_raw = RAW_W'($random(seed));
			if (conv_diode_fault)
				conv_local_raw[2:0] = 3'h0;
			txn(0, CMD_RATE_WR, {5'h00, i[2:0]});
			txn(0, CMD_CFG_WR, {2'h1, i[1], src, 4'h0});
			chk({7'h00, src_out}, {7'h00, src && i < 5});
			k0 = n_starts;
			txn(1, CMD_SINGLE_CONV, 8'h00);
			wait_idle();
			txn(2, CMD_STATUS, 8'h00);
			for (int r = 0; r < 4; r++)
				txn(2, {3'h0, r[1], 3'h0, r[0]}, 8'h00);
			txn(3, 8'h00, 8'h00);
		end
		k0 = n_starts;
		repeat (700) @(negedge sys_clk);
		chk(8'(n_starts - k0), 8'h00);
		txn(0, 8'h00, 8'h55);
		txn(2, 8'h00, 8'h00);
		txn(2, 8'h05, 8'h00);
		host.start();
		host.xfer({7'h19, 1'h0}, 1'h1, rx, a);
		chk({7'h00, a}, 8'h01);
		host.stop();
		// pin standby blocks single and automatic requests
		@(negedge sys_clk);
		hw_standby_n = 1'h0;
		k0 = n_starts;
		txn(1, CMD_SINGLE_CONV, 8'h00);
		txn(0, CMD_CFG_WR, 8'h00);
		repeat (700) @(negedge sys_clk);
		chk(8'(n_starts - k0), 8'h00);
		txn(2, CMD_REMOTE_WHOLE, 8'h00);
		txn(2, CMD_CFG_RD, 8'h00);
		// pin abort, then abort by entering software standby
		conv_len = 600;
		k0 = n_aborts;
		@(negedge sys_clk);
		hw_standby_n = 1'h1;
		wait_busy();
		// busy flag must show while the long conversion runs
		m[2][STAT_BUSY_BIT] = 1'h1;
		txn(2, CMD_STATUS, 8'h00);
		m[2][STAT_BUSY_BIT] = 1'h0;
		hw_standby_n = 1'h0;
		repeat (20) @(negedge sys_clk);
		chk(8'(n_aborts - k0), 8'h01);
		chk({7'h00, adc_enable}, 8'h00);
		hw_standby_n = 1'h1;
		wait_busy();
		txn(0, CMD_CFG_WR, 8'h40);
		repeat (20) @(negedge sys_clk);
		chk(8'(n_aborts - k0), 8'h02);
		txn(2, CMD_LOCAL_WHOLE, 8'h00);
		txn(2, CMD_REMOTE_FRAC, 8'h00);
		report_and_stop();
	end
	// watchdog well beyond the expected run length
	initial begin
		#3_000_000;
		n_errors++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		report_and_stop();
	end
endmodule
